// ===== logic/sifdb_pkg.sv
// Shared constants and types for the serial interrupt-flag and data-buffer block
package sifdb_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int RX_DEPTH = 2;

   localparam logic [ADDR_W-1:0] OFS_LINK_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_DATA      = 3'h4;

   // Link control fields
   localparam int B_ENABLE = 0;
   localparam int B_HOST   = 5;
   // Mode control fields
   localparam int B_BUFFERED = 7;
   localparam int B_SEL_DIS  = 2;
   // Interrupt enable fields
   localparam int B_RX_EN     = 7;
   localparam int B_TX_EN     = 6;
   localparam int B_EMPTY_EN  = 5;
   localparam int B_SEL_EN    = 4;
   localparam int B_NORMAL_EN = 0;
   // Flag fields, normal layout
   localparam int B_TD = 7;
   localparam int B_WC = 6;
   // Flag fields, buffered layout
   localparam int B_RXD     = 7;
   localparam int B_TXD     = 6;
   localparam int B_EMPTY   = 5;
   localparam int B_SELTRIG = 4;
   localparam int B_OVF     = 0;

   localparam logic [DATA_W-1:0] BUF_EN_MASK    = 8'hF0;
   localparam logic [DATA_W-1:0] NORMAL_EN_MASK = 8'h01;
   localparam logic [DATA_W-1:0] RST_BYTE       = 8'h00;

   // Host serial clock half period
   localparam int CLK_MHZ      = 40;
   localparam int SCK_HALF_NS  = 100;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic {LINK_IDLE, LINK_RUN} sifdb_link_e;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sifdb_bus_s;
endpackage

// ===== logic/sifdb_core.sv
// Serial port flag, interrupt enable and data buffer logic with byte shifter
`timescale 1ns/100ps
`default_nettype none

// How it works
// R1: Buffered mode: receive-done enable gates its request; reads zero otherwise.
// R2: Buffered mode: transmit-done enable gates its request; reads zero otherwise.
// R3: Buffered mode: empty enable gates its request; reads zero otherwise.
// R4: Buffered mode: select-trigger enable gates its request; reads zero otherwise.
// R5: Normal mode: one enable raises the request while transfer-done is set.
// R6: Normal mode: transfer-done sets when a byte finishes shifting.
// R7: Normal mode: select pulled low while host, select enabled, also sets transfer-done.
// R8: Transfer-done clears on write one, or flags read then data access.
// R9: Normal mode: data write during an active byte sets the collision flag.
// R10: Collision clears only by flags read with it set, then data access.
// R11: Receive-done follows receive buffer not empty; write one flushes.
// R12: Transmit-done sets when shifting ends with no byte staged; write one clears.
// R13: Empty flag reads one while transmit buffer holds nothing.
// R14: Data write clears empty flag; software must refill or mask it.
// R15: Select fault while host, select enabled, sets select-trigger; write one clears.
// R16: Overflow sets when both receive entries full and a third byte lands.
// R17: With no transmit data waiting, overflow waits for next transfer start.
// R18: Overflow clears on data read or write one.
// R19: Data write starts a host transfer; a client only stages the byte.
// R20: Normal mode: writes load the shifter, reads return receive register.
// R21: Buffered mode: writes fill transmit buffer, reads pop receive head.
// R22: A request stands while enable and flag are both set.
// R23: Buffered mode enables two receive stages and one transmit stage.
// R24: Both flag layouts share one address, chosen by buffered mode.
module sifdb_core #(
   parameter int unsigned SCK_HALF_CYC = sifdb_pkg::SCK_HALF_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire sifdb_pkg::sifdb_bus_s   bus,
   output var  logic [sifdb_pkg::DATA_W-1:0] rdata,
   output wire logic                    irqReq,
   input  wire logic                    sckIn,
   output wire logic                    sckOut,
   output wire logic                    sckOen,
   input  wire logic                    selN,
   input  wire logic                    serialIn,
   output wire logic                    serialOut,
   output wire logic                    serialOen
);
   import sifdb_pkg::*;

   localparam int DIV_W = $clog2(SCK_HALF_CYC) + 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
   localparam logic [2:0] LAST_BIT = 3'(DATA_W - 1);

   function automatic logic flagNext(input logic setEv, input logic clrEv,
                                     input logic cur);
      flagNext = setEv | (cur & ~clrEv);
   endfunction

   logic [1:0]        rstPipe_reg;
   logic              rstSync;
   logic [2:0]        sckSync_reg;
   logic [1:0]        selSync_reg;
   logic [1:0]        sinSync_reg;

   logic              enable_reg, enable_next;
   logic              hostMode_reg, hostMode_next;
   logic              bufMode_reg, bufMode_next;
   logic              selDis_reg, selDis_next;
   logic [DATA_W-1:0] irqEn_reg, irqEn_next;

   logic              tdFlag_reg, tdFlag_next;
   logic              wcFlag_reg, wcFlag_next;
   logic              armTd_reg, armTd_next;
   logic              armWc_reg, armWc_next;
   logic              txDoneFlag_reg, txDoneFlag_next;
   logic              selFlag_reg, selFlag_next;
   logic              ovfFlag_reg, ovfFlag_next;
   logic              ovfPend_reg, ovfPend_next;

   logic [DATA_W-1:0] shiftReg_reg, shiftReg_next;
   logic              outBit_reg, outBit_next;
   logic [2:0]        bitCnt_reg, bitCnt_next;
   logic [DATA_W-1:0] rxData_reg, rxData_next;
   logic [DATA_W-1:0] rxBuf_reg [RX_DEPTH];
   logic [DATA_W-1:0] rxBuf_next [RX_DEPTH];
   logic [1:0]        rxCount_reg, rxCount_next;
   logic [DATA_W-1:0] txBuf_reg, txBuf_next;
   logic              txFull_reg, txFull_next;
   sifdb_link_e       linkState_reg, linkState_next;
   logic [DIV_W-1:0]  div_reg, div_next;
   logic              sckOut_reg, sckOut_next;
   logic [DATA_W-1:0] rdata_next;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstPipe_reg <= '0;
      end else begin
         rstPipe_reg <= {rstPipe_reg[0], 1'h1};
      end
   end
   assign rstSync = rstPipe_reg[1];

   // Pin synchronisers; stage 0 feeds stage 1 only
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         sckSync_reg <= '0;
         selSync_reg <= 2'h3;
         sinSync_reg <= '0;
      end else begin
         sckSync_reg <= {sckSync_reg[1:0], sckIn};
         selSync_reg <= {selSync_reg[0], selN};
         sinSync_reg <= {sinSync_reg[0], serialIn};
      end
   end

   // Register decode
   wire linkWr  = bus.wr && bus.addr == OFS_LINK_CTRL;
   wire modeWr  = bus.wr && bus.addr == OFS_MODE_CTRL;
   wire enWr    = bus.wr && bus.addr == OFS_IRQ_EN;
   wire flagsWr = bus.wr && bus.addr == OFS_IRQ_FLAGS;
   wire flagsRd = bus.rd && bus.addr == OFS_IRQ_FLAGS;
   wire dataWr  = bus.wr && bus.addr == OFS_DATA;
   wire dataRd  = bus.rd && bus.addr == OFS_DATA;
   wire dataAcc = dataWr | dataRd;
   wire [DATA_W-1:0] wd = bus.wdata;

   // Link events
   wire selActive = ~selSync_reg[1];
   wire sckRise   = sckSync_reg[1] & ~sckSync_reg[2];
   wire sckFall   = ~sckSync_reg[1] & sckSync_reg[2];
   wire linkRun   = linkState_reg == LINK_RUN;
   wire hostTick  = linkRun && div_reg == DIV_LAST;
   wire hostRise  = hostTick & ~sckOut_reg;
   wire hostFall  = hostTick & sckOut_reg;
   // Host with select enabled loses the bus when select is pulled low
   wire modeFault = enable_reg & hostMode_reg & ~selDis_reg & selActive;
   wire clientSel = selActive & ~hostMode_reg;
   wire sampleEdge = enable_reg &
                     (hostMode_reg ? hostRise : sckRise & clientSel);
   wire shiftEdge  = enable_reg &
                     (hostMode_reg ? hostFall : sckFall & clientSel);
   wire byteDone   = sampleEdge && bitCnt_reg == LAST_BIT;
   wire [DATA_W-1:0] rxByte = {shiftReg_reg[DATA_W-2:0], sinSync_reg[1]};
   wire txActive = linkRun | (bitCnt_reg != 3'h0) | sampleEdge;

   // Loading the shifter
   wire collision = dataWr & ~bufMode_reg & txActive; // R9
   wire nLoad = dataWr & ~bufMode_reg & ~txActive; // R20
   wire bLoad = bufMode_reg & txFull_reg & ~txActive & enable_reg; // R23
   wire load  = nLoad | bLoad;
   wire [DATA_W-1:0] loadByte = bLoad ? txBuf_reg : wd;
   wire hostStart = load & hostMode_reg & enable_reg; // R19
   wire transferStart = load | (sampleEdge && bitCnt_reg == 3'h0);

   // Receive buffer bookkeeping
   wire rxFlush = flagsWr & bufMode_reg & wd[B_RXD]; // R11
   wire pop  = bufMode_reg & dataRd & (rxCount_reg != 2'h0); // R21
   wire push = bufMode_reg & byteDone &
               ((rxCount_reg != 2'(RX_DEPTH)) | pop);
   wire [1:0] rxBase = rxFlush ? 2'h0 : 2'(rxCount_reg - {1'h0, pop});
   wire fullLoss = bufMode_reg & byteDone & ~push; // R16
   wire ovfSet = (fullLoss & txFull_reg) | (ovfPend_reg & transferStart); // R17
   wire ovfClr = dataRd | (flagsWr & bufMode_reg & wd[B_OVF]); // R18

   // Flag events
   wire tdSet = ~bufMode_reg & (byteDone | modeFault); // R6 R7
   wire tdClr = (flagsWr & ~bufMode_reg & wd[B_TD]) |
                (dataAcc & armTd_reg); // R8
   wire txDoneSet = bufMode_reg & byteDone & ~txFull_reg; // R12
   wire txDoneClr = flagsWr & bufMode_reg & wd[B_TXD];
   wire selSet = modeFault & bufMode_reg; // R15
   wire selClr = flagsWr & bufMode_reg & wd[B_SELTRIG];

   // Register next values
   assign enable_next   = linkWr ? wd[B_ENABLE] : enable_reg;
   assign hostMode_next = modeFault ? 1'h0 :
                          linkWr ? wd[B_HOST] : hostMode_reg;
   assign bufMode_next  = modeWr ? wd[B_BUFFERED] : bufMode_reg;
   assign selDis_next   = modeWr ? wd[B_SEL_DIS] : selDis_reg;
   assign irqEn_next    = enWr ? (wd & (BUF_EN_MASK | NORMAL_EN_MASK))
                               : irqEn_reg;

   assign tdFlag_next = flagNext(tdSet, tdClr, tdFlag_reg);
   assign wcFlag_next = flagNext(collision, dataAcc & armWc_reg,
                                 wcFlag_reg); // R10
   assign armTd_next  = (flagsRd & ~bufMode_reg) ? tdFlag_reg :
                        dataAcc ? 1'h0 : armTd_reg;
   assign armWc_next  = (flagsRd & ~bufMode_reg) ? wcFlag_reg :
                        dataAcc ? 1'h0 : armWc_reg;
   assign txDoneFlag_next = flagNext(txDoneSet, txDoneClr, txDoneFlag_reg);
   assign selFlag_next = flagNext(selSet, selClr, selFlag_reg);
   assign ovfFlag_next = flagNext(ovfSet, ovfClr, ovfFlag_reg);
   assign ovfPend_next = (fullLoss & ~txFull_reg) |
                         (ovfPend_reg & ~transferStart);

   assign shiftReg_next = load ? loadByte :
                          sampleEdge ? rxByte : shiftReg_reg;
   assign outBit_next   = load ? loadByte[DATA_W-1] :
                          shiftEdge ? shiftReg_reg[DATA_W-1] : outBit_reg;
   // A deselected client or a dropped host restarts at bit zero
   assign bitCnt_next = (~enable_reg | modeFault |
                         (~hostMode_reg & ~selActive)) ? 3'h0 :
                        sampleEdge ? 3'(bitCnt_reg + 3'h1) : bitCnt_reg;
   assign rxData_next = byteDone ? rxByte : rxData_reg; // R20

   // Write beats a same-cycle load: old byte goes out, new one waits
   assign txFull_next = (bufMode_reg & dataWr) ? 1'h1 : // R14
                        (bLoad | ~bufMode_reg) ? 1'h0 : txFull_reg;
   assign txBuf_next  = (bufMode_reg & dataWr) ? wd : txBuf_reg; // R21

   always_comb begin
      rxBuf_next[0] = (pop & ~rxFlush) ? rxBuf_reg[1] : rxBuf_reg[0];
      rxBuf_next[1] = rxBuf_reg[1];
      if (push) begin
         rxBuf_next[rxBase[0]] = rxByte;
      end
   end
   assign rxCount_next = 2'(rxBase + {1'h0, push});

   always_comb begin
      linkState_next = linkState_reg;
      unique case (linkState_reg)
         LINK_IDLE: begin
            if (hostStart) begin
               linkState_next = LINK_RUN; // R19
            end
         end
         LINK_RUN: begin
            if (~enable_reg | modeFault |
                (hostFall && bitCnt_reg == 3'h0)) begin
               linkState_next = LINK_IDLE;
            end
         end
      endcase
   end
   assign div_next    = (linkRun & ~hostTick) ? DIV_W'(div_reg + 1'h1)
                                              : '0;
   assign sckOut_next = linkRun & (sckOut_reg ^ hostTick);

   // Readback views; enables of the other layout read zero
   wire [DATA_W-1:0] enView = irqEn_reg &
        (bufMode_reg ? BUF_EN_MASK : NORMAL_EN_MASK); // R1 R2 R3 R4
   logic [DATA_W-1:0] flagsView;
   always_comb begin
      flagsView = '0;
      if (bufMode_reg) begin // R24
         flagsView[B_RXD]     = rxCount_reg != 2'h0; // R11
         flagsView[B_TXD]     = txDoneFlag_reg;
         flagsView[B_EMPTY]   = ~txFull_reg; // R13
         flagsView[B_SELTRIG] = selFlag_reg;
         flagsView[B_OVF]     = ovfFlag_reg;
      end else begin
         flagsView[B_TD] = tdFlag_reg;
         flagsView[B_WC] = wcFlag_reg;
      end
   end

   // Request stands while flag and enable are both set
   assign irqReq = bufMode_reg ? |(enView & flagsView) // R22
                               : enView[B_NORMAL_EN] & tdFlag_reg; // R5

   logic [DATA_W-1:0] readMux;
   always_comb begin
      readMux = '0;
      unique case (bus.addr)
         OFS_LINK_CTRL: begin
            readMux[B_ENABLE] = enable_reg;
            readMux[B_HOST]   = hostMode_reg;
         end
         OFS_MODE_CTRL: begin
            readMux[B_BUFFERED] = bufMode_reg;
            readMux[B_SEL_DIS]  = selDis_reg;
         end
         OFS_IRQ_EN:    readMux = enView;
         OFS_IRQ_FLAGS: readMux = flagsView;
         OFS_DATA:      readMux = bufMode_reg ? rxBuf_reg[0] : rxData_reg;
         default:       readMux = '0;
      endcase
   end
   assign rdata_next = bus.rd ? readMux : '0;

   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         enable_reg     <= 1'h0;
         hostMode_reg   <= 1'h0;
         bufMode_reg    <= 1'h0;
         selDis_reg     <= 1'h0;
         irqEn_reg      <= RST_BYTE;
         tdFlag_reg     <= 1'h0;
         wcFlag_reg     <= 1'h0;
         armTd_reg      <= 1'h0;
         armWc_reg      <= 1'h0;
         txDoneFlag_reg <= 1'h0;
         selFlag_reg    <= 1'h0;
         ovfFlag_reg    <= 1'h0;
         ovfPend_reg    <= 1'h0;
      end else begin
         enable_reg     <= enable_next;
         hostMode_reg   <= hostMode_next;
         bufMode_reg    <= bufMode_next;
         selDis_reg     <= selDis_next;
         irqEn_reg      <= irqEn_next;
         tdFlag_reg     <= tdFlag_next;
         wcFlag_reg     <= wcFlag_next;
         armTd_reg      <= armTd_next;
         armWc_reg      <= armWc_next;
         txDoneFlag_reg <= txDoneFlag_next;
         selFlag_reg    <= selFlag_next;
         ovfFlag_reg    <= ovfFlag_next;
         ovfPend_reg    <= ovfPend_next;
      end
   end

   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         shiftReg_reg  <= RST_BYTE;
         outBit_reg    <= 1'h0;
         bitCnt_reg    <= 3'h0;
         rxData_reg    <= RST_BYTE;
         rxBuf_reg[0]  <= RST_BYTE;
         rxBuf_reg[1]  <= RST_BYTE;
         rxCount_reg   <= 2'h0;
         txBuf_reg     <= RST_BYTE;
         txFull_reg    <= 1'h0;
         linkState_reg <= LINK_IDLE;
         div_reg       <= '0;
         sckOut_reg    <= 1'h0;
         rdata         <= RST_BYTE;
      end else begin
         shiftReg_reg  <= shiftReg_next;
         outBit_reg    <= outBit_next;
         bitCnt_reg    <= bitCnt_next;
         rxData_reg    <= rxData_next;
         rxBuf_reg[0]  <= rxBuf_next[0];
         rxBuf_reg[1]  <= rxBuf_next[1];
         rxCount_reg   <= rxCount_next;
         txBuf_reg     <= txBuf_next;
         txFull_reg    <= txFull_next;
         linkState_reg <= linkState_next;
         div_reg       <= div_next;
         sckOut_reg    <= sckOut_next;
         rdata         <= rdata_next;
      end
   end

   // Pins; enables are low while driving
   assign sckOut    = sckOut_reg;
   assign sckOen    = ~(enable_reg & hostMode_reg);
   assign serialOut = outBit_reg;
   assign serialOen = ~(enable_reg & (hostMode_reg | selActive));

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync);

   a_rx_irq_gate: assert property ( // R1
      bufMode_reg && irqEn_reg[B_RX_EN] && rxCount_reg != 2'h0 |-> irqReq)
      else $error("receive-done request missing");
   a_tx_irq_gate: assert property ( // R2
      bufMode_reg && irqEn_reg[B_TX_EN] && txDoneFlag_reg |-> irqReq)
      else $error("transmit-done request missing");
   a_empty_irq_gate: assert property ( // R3
      bufMode_reg && irqEn_reg[B_EMPTY_EN] && !txFull_reg |-> irqReq)
      else $error("empty request missing");
   a_normal_irq_gate: assert property ( // R5
      !bufMode_reg && !irqEn_reg[B_NORMAL_EN] |-> !irqReq)
      else $error("normal request without enable");
   a_byte_sets_done: assert property ( // R6
      !bufMode_reg && !modeWr && byteDone |=> tdFlag_reg)
      else $error("transfer-done not set after byte");

   sequence s_done_seen;
      flagsRd && !bufMode_reg && tdFlag_reg;
   endsequence
   sequence s_data_touch;
      dataAcc && !tdSet && !modeWr;
   endsequence
   a_read_then_touch: assert property ( // R8
      s_done_seen ##1 !dataAcc ##1 s_data_touch |=> !tdFlag_reg)
      else $error("transfer-done not cleared by read then access");

   a_collision_flag: assert property ( // R9
      !bufMode_reg && dataWr && txActive |=> wcFlag_reg)
      else $error("collision flag not set");
   a_write_fills: assert property ( // R14
      bufMode_reg && !modeWr && dataWr |=> !flagsView[B_EMPTY])
      else $error("empty flag still set after write");
   a_select_fault: assert property ( // R15
      modeFault && bufMode_reg && !modeWr |=> selFlag_reg && !hostMode_reg)
      else $error("select fault not recorded");
   a_overflow_set: assert property ( // R16
      fullLoss && txFull_reg |=> ovfFlag_reg)
      else $error("overflow not flagged");
   a_overflow_clear: assert property ( // R18
      dataRd && !ovfSet |=> !ovfFlag_reg)
      else $error("overflow not cleared by data read");
   a_host_start: assert property ( // R19
      hostStart && !modeFault |=> linkRun ##1 linkRun)
      else $error("host transfer did not start");
   a_rx_pop: assert property ( // R21
      pop && !push && !rxFlush && rxCount_reg == 2'h2 |=>
      rxCount_reg == 2'h1)
      else $error("receive buffer did not advance");
endmodule

`default_nettype wire

// ===== verif/sifdb_peer.sv
// Far-side serial peer: client while the block hosts, host while it listens
`timescale 1ns/100ps
`default_nettype none
module sifdb_peer (
   input  wire logic sckOut,
   input  wire logic serialOut,
   output var  logic sckIn,
   output var  logic selN,
   output wire logic serialIn
);
   logic [7:0] cur;
   logic [7:0] got;
   logic       hostRole;
   logic       hData;

   // Shifting in an inverted bit keeps the line toggling after a frame
   assign serialIn = hostRole ? hData : cur[7];

   initial begin
      cur = 8'h00;
      got = 8'h00;
      hostRole = 1'b0;
      hData = 1'b0;
      sckIn = 1'b0;
      selN = 1'b1;
   end

   always @(posedge sckOut) begin
      got = {got[6:0], serialOut};
   end

   always @(negedge sckOut) begin
      cur = {cur[6:0], ~cur[0]};
   end

   // Sampled late in the high phase; the block moves its line on falls
   task automatic host_xfer(input logic [7:0] tx, output logic [7:0] rx);
      #7;
      hostRole = 1'b1;
      hData = tx[7];
      selN = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         hData = tx[i];
         #100;
         sckIn = 1'b1;
         #95;
         rx = {rx[6:0], serialOut};
         #5;
         sckIn = 1'b0;
      end
      #100;
      hData = ~hData;
      selN = 1'b1;
      #100;
      hostRole = 1'b0;
   endtask

   task automatic pull_sel;
      #7;
      selN = 1'b0;
      #300;
      selN = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== verif/spi_irq_flags_data_buffer_bench.sv
// Self-checking bench: register traffic and serial peer against a model
`timescale 1ns/100ps
`default_nettype none
module spi_irq_flags_data_buffer_bench;
   import sifdb_pkg::*;
   logic              clk;
   logic              rstn;
   sifdb_bus_s        bus;
   wire logic [7:0]   rdata;
   wire logic         irqReq, sckOut, sckOen, serialOut, serialOen;
   wire logic         sckIn, selN, serialIn;
   int                fails;
   int                cmpCount;
   logic [7:0]        d;
   logic [7:0]        w;
   logic [7:0]        rxq[$];

   sifdb_core sifdb_core_inst (
      .clk       (clk),
      .rstn      (rstn),
      .bus       (bus),
      .rdata     (rdata),
      .irqReq    (irqReq),
      .sckIn     (sckIn),
      .sckOut    (sckOut),
      .sckOen    (sckOen),
      .selN      (selN),
      .serialIn  (serialIn),
      .serialOut (serialOut),
      .serialOen (serialOen)
   );

   sifdb_peer peer_inst (
      .sckOut    (sckOut),
      .serialOut (serialOut),
      .sckIn     (sckIn),
      .selN      (selN),
      .serialIn  (serialIn)
   );

   always #12.5 clk = ~clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic expect_rd(input logic [2:0] a, input logic [7:0] m,
                            input logic [7:0] e);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      bus <= '0;
      #1;
      d = rdata;
      check(d & m, e);
   endtask

   task automatic irq_is(input logic e);
      #1;
      check({7'h00, irqReq}, {7'h00, e});
   endtask

   // One byte is 16 half periods of 4 clocks plus sync slack
   task automatic send(input logic twice);
      logic [7:0] v;
      logic [7:0] p;
      v = 8'($urandom);
      p = 8'($urandom);
      peer_inst.cur = p;
      rxq.push_back(p);
      wr(OFS_DATA, v);
      if (twice) begin
         wr(OFS_DATA, ~v);
      end
      repeat (72) @(posedge clk);
      check(peer_inst.got, v);
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #500000;
      fails++;
      finish_test();
   end

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      bus = '0;
      fails = 0;
      cmpCount = 0;
      void'($urandom(32'h86c806a3));
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 0; a < 6; a++) begin
         expect_rd(3'(a), 8'hFF, 8'h00);
      end
      // Normal host transfer, then clear by flags read and data read
      wr(OFS_LINK_CTRL, 8'h21);
      wr(OFS_IRQ_EN, 8'hF1);
      expect_rd(OFS_IRQ_EN, 8'hFF, NORMAL_EN_MASK);
      check({7'h00, sckOen}, 8'h00);
      check({7'h00, serialOen}, 8'h00);
      send(1'b0);
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'h80);
      irq_is(1'b1);
      expect_rd(OFS_DATA, 8'hFF, rxq.pop_front());
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'h00);
      irq_is(1'b0);
      // Second write lands mid-byte and must be dropped
      send(1'b1);
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'hC0);
      wr(OFS_IRQ_FLAGS, 8'hC0);
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'h40);
      expect_rd(OFS_DATA, 8'hFF, rxq.pop_front());
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'h00);
      peer_inst.pull_sel();
      repeat (4) @(posedge clk);
      expect_rd(OFS_LINK_CTRL, 8'hFF, 8'h01);
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'h80);
      wr(OFS_IRQ_FLAGS, 8'h80);
      // Buffered mode with select disable set
      wr(OFS_MODE_CTRL, 8'h84);
      wr(OFS_LINK_CTRL, 8'h21);
      expect_rd(OFS_IRQ_EN, 8'hFF, BUF_EN_MASK);
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'h20);
      irq_is(1'b1);
      wr(OFS_IRQ_EN, 8'h00);
      irq_is(1'b0);
      peer_inst.pull_sel();
      repeat (4) @(posedge clk);
      expect_rd(OFS_LINK_CTRL, 8'hFF, 8'h21);
      for (int i = 0; i < 3; i++) begin
         send(1'b0);
      end
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'hE0);
      peer_inst.cur = 8'($urandom);
      wr(OFS_DATA, 8'($urandom));
      wr(OFS_DATA, 8'($urandom));
      expect_rd(OFS_IRQ_FLAGS, 8'h21, 8'h01);
      wr(OFS_IRQ_FLAGS, 8'h01);
      expect_rd(OFS_IRQ_FLAGS, 8'h01, 8'h00);
      // Staged byte waits while the full buffer loses the running one
      repeat (70) @(posedge clk);
      expect_rd(OFS_IRQ_FLAGS, 8'h01, 8'h01);
      expect_rd(OFS_DATA, 8'hFF, rxq.pop_front());
      expect_rd(OFS_IRQ_FLAGS, 8'h01, 8'h00);
      expect_rd(OFS_DATA, 8'hFF, rxq.pop_front());
      repeat (150) @(posedge clk);
      wr(OFS_IRQ_FLAGS, 8'hC0);
      expect_rd(OFS_IRQ_FLAGS, 8'hE0, 8'h20);
      // Select fault now honoured
      wr(OFS_MODE_CTRL, 8'h80);
      peer_inst.pull_sel();
      repeat (4) @(posedge clk);
      expect_rd(OFS_LINK_CTRL, 8'hFF, 8'h01);
      expect_rd(OFS_IRQ_FLAGS, 8'h10, 8'h10);
      check({7'h00, serialOen}, 8'h01);
      wr(OFS_IRQ_EN, 8'h10);
      irq_is(1'b1);
      wr(OFS_IRQ_FLAGS, 8'h10);
      irq_is(1'b0);
      // Normal client: byte only staged until the peer hosts a frame
      wr(OFS_MODE_CTRL, 8'h00);
      w = 8'($urandom);
      wr(OFS_DATA, w);
      peer_inst.host_xfer(8'h3C, d);
      check(d, w);
      repeat (4) @(posedge clk);
      expect_rd(OFS_IRQ_FLAGS, 8'hFF, 8'h80);
      expect_rd(OFS_DATA, 8'hFF, 8'h3C);
      finish_test();
   end
endmodule
`default_nettype wire
